// File: design/spi_port_pkg.sv
// Register map, field positions and types of the framed serial port
package spi_port_pkg;
    // Word-aligned byte offsets on the register bus
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CON1 = 4'h4;
    localparam logic [3:0] OFS_CON2 = 4'h8;
    localparam logic [3:0] OFS_DATA = 4'hC;
    // port_status_control fields
    localparam int ST_EN = 15;
    localparam int ST_SIDL = 13;
    localparam int ST_ROV = 6;
    localparam int ST_TBF = 1;
    localparam int ST_RBF = 0;
    // port_control_one fields
    localparam int C1_CLK_DIS = 12;
    localparam int C1_DOUT_DIS = 11;
    localparam int C1_WIDE = 10;
    localparam int C1_SMP = 9;
    localparam int C1_EDGE = 8;
    localparam int C1_SELECT_PIN_ENABLE = 7;
    localparam int C1_CKP = 6;
    localparam int C1_MASTER = 5;
    localparam int C1_SEC_LSB = 2;
    localparam int C1_PRI_LSB = 0;
    // port_control_two fields
    localparam int C2_FRM = 15;
    localparam int C2_DIR = 14;
    localparam int C2_POL = 13;
    localparam int C2_DLY = 1;
    // Writable bits and reset values
    localparam logic [15:0] ST_WMASK = 16'hA000;
    localparam logic [15:0] C1_WMASK = 16'h1FFF;
    localparam logic [15:0] C2_WMASK = 16'hE002;
    localparam logic [15:0] ST_RESET = 16'h0000;
    localparam logic [15:0] C1_RESET = 16'h0000;
    localparam logic [15:0] C2_RESET = 16'h0000;
    // Word lengths in bits
    localparam logic [4:0] BITS_WIDE = 5'h10;
    localparam logic [4:0] BITS_NARROW = 5'h08;
    localparam int DIV_W = 10;

    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_SYNC,
        ENG_SHIFT
    } eng_state_e;

    // Primary ratio: 3 -> 1, 2 -> 4, 1 -> 16, 0 -> 64
    function automatic logic [DIV_W-1:0] pri_ratio(input logic [1:0] code);
        unique case (code)
            2'h3: pri_ratio = 10'h001;
            2'h2: pri_ratio = 10'h004;
            2'h1: pri_ratio = 10'h010;
            default: pri_ratio = 10'h040;
        endcase
    endfunction

    // Secondary ratio: 7 -> 1 down to 0 -> 8
    function automatic logic [DIV_W-1:0] sec_ratio(input logic [2:0] code);
        sec_ratio = 10'h008 - {7'h00, code};
    endfunction
endpackage

// File: design/spi_framed_port.sv
// Framed serial port with master/slave shift engine and Avalon-MM register slave
//
// How it works
// - Enable bit hands the four serial pins to the port; clear disables everything.
// - Stop-in-idle bit freezes the port while the device idles.
// - Word finished while previous unread is dropped and sets the overflow flag.
// - Data write sets transmit-full; moving the word into the shifter clears it.
// - Received word moving to receive holder sets receive-full; data read clears it.
// - One 16-bit shifter, reached by software only through the data location.
// - Master drives the shift clock; slave takes it from the pin.
// - Master with clock-pin disable keeps the clock off the pin.
// - Data-out disable leaves the serial output pin undriven.
// - Width select picks 16-bit words or 8-bit bytes.
// - Master samples input at end of data time when set, middle when clear.
// - Edge select set changes data active-to-idle, clear idle-to-active.
// - Slave with select enable only shifts while active-low select is low.
// - Clock idle level set idles the clock high, clear idles it low.
// - Master select chooses master or slave operation.
// - Framed mode turns the select pin into a frame sync pulse.
// - Sync direction set takes the pulse in; clear has the master drive it out.
// - Sync polarity set gives an active-high pulse, clear active-low.
// - Sync timing set puts a driven pulse on the first bit, clear one bit earlier.
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module spi_framed_port (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // Register bus
    input wire logic [spi_port_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Device power state
    input wire logic idle_mode_i,
    // Shift clock pin
    input wire logic shift_clock_pin_i,
    output logic shift_clock_pin_o,
    output logic shift_clock_pin_oe_n_o,
    // Serial data pins
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_n_o,
    // Select / frame sync pin
    input wire logic select_pin_i,
    output logic select_pin_o,
    output logic select_pin_oe_n_o
);
    // Register state
    logic [15:0] stat_reg;
    logic [15:0] con1_reg;
    logic [15:0] con2_reg;
    logic rov_reg;
    logic tbf_reg;
    logic rbf_reg;
    logic [15:0] tx_hold_reg;
    logic [15:0] rx_hold_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;

    // Pin synchronisers
    logic sck_s1_reg;
    logic sck_s2_reg;
    logic sck_s3_reg;
    logic sdi_s1_reg;
    logic sdi_s2_reg;
    logic sel_s1_reg;
    logic sel_s2_reg;

    // Engine state
    spi_port_pkg::eng_state_e state_reg;
    spi_port_pkg::eng_state_e state_next;
    logic [15:0] sr_reg;
    logic [15:0] sr_next;
    logic in_bit_reg;
    logic in_bit_next;
    logic [4:0] bitcnt_reg;
    logic [4:0] bitcnt_next;
    logic [5:0] k_reg;
    logic [5:0] k_next;
    logic sck_act_reg;
    logic sck_act_next;
    logic fs_reg;
    logic fs_next;
    logic arm_reg;
    logic arm_next;
    logic [spi_port_pkg::DIV_W-1:0] div_reg;
    logic load_tx;
    logic done;

    // Bus decode
    wire req = avs_read_i | avs_write_i;
    wire wr_acc = avs_write_i & ack_reg;
    wire rd_acc = avs_read_i & ack_reg;
    wire sel_stat = avs_address_i == spi_port_pkg::OFS_STATUS;
    wire sel_con1 = avs_address_i == spi_port_pkg::OFS_CON1;
    wire sel_con2 = avs_address_i == spi_port_pkg::OFS_CON2;
    wire sel_data = avs_address_i == spi_port_pkg::OFS_DATA;
    wire data_wr = wr_acc & sel_data;
    wire data_rd = rd_acc & sel_data;

    // Overflow is R/C: a zero written in the low lane clears it
    wire rov_clr = wr_acc & sel_stat & avs_byteenable_i[0]
        & ~avs_writedata_i[spi_port_pkg::ST_ROV];

    // Configuration fields
    wire en = stat_reg[spi_port_pkg::ST_EN];
    wire run = en & ~(stat_reg[spi_port_pkg::ST_SIDL] & idle_mode_i);
    wire clk_dis = con1_reg[spi_port_pkg::C1_CLK_DIS];
    wire dout_dis = con1_reg[spi_port_pkg::C1_DOUT_DIS];
    wire wide = con1_reg[spi_port_pkg::C1_WIDE];
    wire input_sample_phase = con1_reg[spi_port_pkg::C1_SMP];
    wire select_pin_enable = con1_reg[spi_port_pkg::C1_SELECT_PIN_ENABLE];
    wire clock_idle_level = con1_reg[spi_port_pkg::C1_CKP];
    wire master = con1_reg[spi_port_pkg::C1_MASTER];
    wire framed = con2_reg[spi_port_pkg::C2_FRM];
    wire fs_in_dir = con2_reg[spi_port_pkg::C2_DIR];
    wire fs_pol = con2_reg[spi_port_pkg::C2_POL];
    wire fs_dly = con2_reg[spi_port_pkg::C2_DLY];

    // Edge select has no meaning in framed mode, so it is forced low there
    wire cke = con1_reg[spi_port_pkg::C1_EDGE] & ~framed;
    wire [4:0] nbits = wide ? spi_port_pkg::BITS_WIDE : spi_port_pkg::BITS_NARROW;
    wire [spi_port_pkg::DIV_W-1:0] divisor = spi_port_pkg::DIV_W'(
        spi_port_pkg::pri_ratio(con1_reg[spi_port_pkg::C1_PRI_LSB +: 2])
        * spi_port_pkg::sec_ratio(con1_reg[spi_port_pkg::C1_SEC_LSB +: 3]));
    wire sdo_bit = wide ? sr_reg[15] : sr_reg[7];

    // Master timing: one tick per half shift-clock period
    wire tick = master & run & (state_reg != spi_port_pkg::ENG_IDLE)
        & (div_reg == divisor - 10'h001);
    wire [5:0] k_n = k_reg + 6'h01;
    wire [5:0] two_n = {nbits, 1'b0};
    wire m_shift = tick & (state_reg == spi_port_pkg::ENG_SHIFT);
    wire m_edge = m_shift & (k_n <= two_n);
    wire m_mid = m_edge & (cke ? k_n[0] : ~k_n[0]);
    wire m_chg = m_shift & (cke ? ~k_n[0] : (k_n[0] & (k_n != 6'h01)));

    // Slave edges from the synchronised pin; third stage only stores history
    wire act_now = sck_s2_reg ^ clock_idle_level;
    wire act_prev = sck_s3_reg ^ clock_idle_level;
    wire lead_s = act_now & ~act_prev;
    wire trail_s = ~act_now & act_prev;
    wire fs_in_act = fs_pol ? sel_s2_reg : ~sel_s2_reg;
    wire ss_low_ok = ~select_pin_enable | framed | ~sel_s2_reg;
    wire s_go = ~master & run & ss_low_ok
        & (~framed | arm_reg | (bitcnt_reg != 5'h00));
    wire s_mid = s_go & (cke ? lead_s : trail_s);
    wire s_chg = s_go & (cke ? trail_s : (lead_s & (bitcnt_reg != 5'h00)));
    // Slave with change on leading edge has no edge after its last bit
    wire s_final = s_mid & ~cke & (bitcnt_reg == nbits - 5'h01);

    wire ev_mid = m_mid | (s_mid & ~s_final);
    wire ev_chg = m_chg | s_chg | s_final;
    // Sample at end of data time only for master; slave always mid-time
    wire chg_bit = s_final | (master & input_sample_phase) ? sdi_s2_reg : in_bit_reg;
    wire master_start = master & run & (state_reg == spi_port_pkg::ENG_IDLE) & tbf_reg
        & (~framed | ~fs_in_dir | arm_reg);

    // Shift engine next state
    always_comb begin
        state_next = state_reg;
        sr_next = sr_reg;
        in_bit_next = in_bit_reg;
        bitcnt_next = bitcnt_reg;
        k_next = k_reg;
        sck_act_next = sck_act_reg;
        fs_next = fs_reg;
        arm_next = arm_reg;
        load_tx = 1'b0;
        done = 1'b0;
        if (framed & fs_in_dir & fs_in_act & (bitcnt_reg == 5'h00)) begin
            arm_next = 1'b1;
        end

        if (master_start) begin
            sr_next = tx_hold_reg;
            load_tx = 1'b1;
            bitcnt_next = 5'h00;
            k_next = 6'h00;
            fs_next = framed & ~fs_in_dir;
            arm_next = 1'b0;
            state_next = (framed & ~fs_in_dir & ~fs_dly) ? spi_port_pkg::ENG_SYNC
                : spi_port_pkg::ENG_SHIFT;
        end else if (~master & run & (bitcnt_reg == 5'h00) & tbf_reg & ~ev_chg & ~ev_mid) begin
            sr_next = tx_hold_reg;
            load_tx = 1'b1;
        end

        if (tick) begin
            k_next = k_n;
            if (k_n == 6'h02) begin
                fs_next = 1'b0;
            end
            if (state_reg == spi_port_pkg::ENG_SYNC & k_n == 6'h02) begin
                k_next = 6'h00;
                state_next = spi_port_pkg::ENG_SHIFT;
            end
        end

        if (m_edge) begin
            sck_act_next = ~sck_act_reg;
        end
        if (ev_mid) begin
            in_bit_next = sdi_s2_reg;
        end
        if (ev_chg) begin
            sr_next = {sr_reg[14:0], chg_bit};
            bitcnt_next = bitcnt_reg + 5'h01;
            if (bitcnt_next == nbits) begin
                bitcnt_next = 5'h00;
                done = 1'b1;
                arm_next = 1'b0;
                state_next = spi_port_pkg::ENG_IDLE;
            end
        end

        // Select high mid-word throws the partial word away
        if (~master & select_pin_enable & ~framed & sel_s2_reg) begin
            bitcnt_next = 5'h00;
        end

        if (~en) begin
            state_next = spi_port_pkg::ENG_IDLE;
            bitcnt_next = 5'h00;
            k_next = 6'h00;
            sck_act_next = 1'b0;
            fs_next = 1'b0;
            arm_next = 1'b0;
        end
    end

    // Register bus answer: one wait state, read data latched before release
    assign avs_waitrequest_o = req & ~ack_reg;
    assign avs_readdata_o = rdata_reg;
    wire [15:0] stat_view = (stat_reg & spi_port_pkg::ST_WMASK)
        | {9'h000, rov_reg, 4'h0, tbf_reg, rbf_reg};
    wire [15:0] rd_mux = sel_stat ? stat_view
        : sel_con1 ? con1_reg
        : sel_con2 ? con2_reg
        : sel_data ? rx_hold_reg
        : 16'h0000;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be, input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
        merge = (old & ~lanes) | (wd & lanes);
    endfunction

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            // A request held past its accept is taken again
            ack_reg <= req & ~ack_reg;
            if (avs_read_i & ~ack_reg) begin
                rdata_reg <= {16'h0000, rd_mux};
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            stat_reg <= spi_port_pkg::ST_RESET;
            con1_reg <= spi_port_pkg::C1_RESET;
            con2_reg <= spi_port_pkg::C2_RESET;
            tx_hold_reg <= 16'h0000;
        end else begin
            if (wr_acc & sel_stat) begin
                stat_reg <= merge(stat_reg, avs_writedata_i[15:0],
                    avs_byteenable_i[1:0], spi_port_pkg::ST_WMASK);
            end

            if (wr_acc & sel_con1) begin
                con1_reg <= merge(con1_reg, avs_writedata_i[15:0],
                    avs_byteenable_i[1:0], spi_port_pkg::C1_WMASK);
            end

            if (wr_acc & sel_con2) begin
                con2_reg <= merge(con2_reg, avs_writedata_i[15:0],
                    avs_byteenable_i[1:0], spi_port_pkg::C2_WMASK);
            end

            if (data_wr) begin
                tx_hold_reg <= merge(tx_hold_reg, avs_writedata_i[15:0],
                    avs_byteenable_i[1:0], 16'hFFFF);
            end
        end
    end

    // Flags: hardware set wins over a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            tbf_reg <= 1'b0;
            rbf_reg <= 1'b0;
            rov_reg <= 1'b0;
            rx_hold_reg <= 16'h0000;
        end else begin
            tbf_reg <= data_wr | (tbf_reg & ~load_tx);
            if (done & rbf_reg & ~data_rd) begin
                rov_reg <= 1'b1;
            end else if (rov_clr) begin
                rov_reg <= 1'b0;
            end
            if (done & ~(rbf_reg & ~data_rd)) begin
                rx_hold_reg <= wide ? sr_next : {8'h00, sr_next[7:0]};
                rbf_reg <= 1'b1;
            end else if (data_rd) begin
                rbf_reg <= 1'b0;
            end
        end
    end

    // Outside signals pass two flip-flops before use
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            {sck_s1_reg, sck_s2_reg, sck_s3_reg} <= 3'h0;
            {sdi_s1_reg, sdi_s2_reg} <= 2'h0;
            {sel_s1_reg, sel_s2_reg} <= 2'h3;
        end else begin
            {sck_s1_reg, sck_s2_reg, sck_s3_reg} <= {shift_clock_pin_i, sck_s1_reg, sck_s2_reg};
            {sdi_s1_reg, sdi_s2_reg} <= {serial_in_pin_i, sdi_s1_reg};
            {sel_s1_reg, sel_s2_reg} <= {select_pin_i, sel_s1_reg};
        end
    end

    // Restarts each tick, so a new ratio applies from the next half period
    always_ff @(posedge mclk_i) begin
        if (srst_i | ~master | ~run | (state_reg == spi_port_pkg::ENG_IDLE) | tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 10'h001;
        end
    end

    // Halting for idle freezes the engine without losing its place
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg <= spi_port_pkg::ENG_IDLE;
            sr_reg <= 16'h0000;
            in_bit_reg <= 1'b0;
            bitcnt_reg <= 5'h00;
            k_reg <= 6'h00;
            sck_act_reg <= 1'b0;
            fs_reg <= 1'b0;
            arm_reg <= 1'b0;
        end else if (run | ~en) begin
            state_reg <= state_next;
            sr_reg <= sr_next;
            in_bit_reg <= in_bit_next;
            bitcnt_reg <= bitcnt_next;
            k_reg <= k_next;
            sck_act_reg <= sck_act_next;
            fs_reg <= fs_next;
            arm_reg <= arm_next;
        end
    end

    // Pin drive; enables are active low, released pins go back to general I/O
    assign shift_clock_pin_o = sck_act_reg ^ clock_idle_level;
    assign shift_clock_pin_oe_n_o = ~(en & master & ~clk_dis);
    assign serial_out_pin_o = sdo_bit;
    assign serial_out_pin_oe_n_o = ~(en & ~dout_dis);
    assign select_pin_o = fs_pol ? fs_reg : ~fs_reg;
    assign select_pin_oe_n_o = ~(en & master & framed & ~fs_in_dir);
endmodule
`default_nettype wire

// File: dv/spi_framed_port_props.sv
// Checker of the framed serial port's bus timing and pin ownership
`timescale 1ns/1ps
`default_nettype none
module spi_framed_port_props (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // Register bus
    input wire logic [spi_port_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Pin enables
    input wire logic shift_clock_pin_oe_n_o,
    input wire logic serial_out_pin_oe_n_o,
    input wire logic select_pin_oe_n_o
);
    logic en_reg;
    logic [15:0] c1_reg;
    wire logic wr_ok = avs_write_i && !avs_waitrequest_o;
    wire logic mst = en_reg && c1_reg[spi_port_pkg::C1_MASTER];
    wire logic clk_dis = c1_reg[spi_port_pkg::C1_CLK_DIS];
    // Shadow of the enable and control-one fields that decide pin ownership, updated at the accept edge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            en_reg <= 1'b0;
            c1_reg <= 16'h0000;
        end else if (wr_ok && avs_address_i == spi_port_pkg::OFS_STATUS) begin
            en_reg <= avs_writedata_i[spi_port_pkg::ST_EN];
        end else if (wr_ok && avs_address_i == spi_port_pkg::OFS_CON1) begin
            c1_reg <= avs_writedata_i[15:0] & spi_port_pkg::C1_WMASK;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus answer not after one wait state");
    idle_bus_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest high without request");
    unmapped_zero_a: assert property (
        avs_read_i && !avs_waitrequest_o && avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    off_float_a: assert property (!en_reg |-> shift_clock_pin_oe_n_o && serial_out_pin_oe_n_o && select_pin_oe_n_o)
        else $error("disabled port drives a pin");
    clk_out_a: assert property (mst && !clk_dis |-> !shift_clock_pin_oe_n_o)
        else $error("master does not drive clock pin");
    clk_off_a: assert property (mst && clk_dis |-> shift_clock_pin_oe_n_o)
        else $error("clock pin driven while disabled");
    slave_clk_a: assert property (en_reg && !c1_reg[spi_port_pkg::C1_MASTER] |-> shift_clock_pin_oe_n_o)
        else $error("slave drives clock pin");
    dout_off_a: assert property (c1_reg[spi_port_pkg::C1_DOUT_DIS] |-> serial_out_pin_oe_n_o)
        else $error("data out driven while disabled");
endmodule
bind spi_framed_port spi_framed_port_props spi_framed_port_props_inst (.mclk_i(mclk_i), .srst_i(srst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .shift_clock_pin_oe_n_o(shift_clock_pin_oe_n_o), .serial_out_pin_oe_n_o(serial_out_pin_oe_n_o),
    .select_pin_oe_n_o(select_pin_oe_n_o));
`default_nettype wire

// File: dv/spi_far_model.sv
// Behavioural far-side serial device; takes the link clock or makes it itself
`timescale 1ns/1ps
`default_nettype none
module spi_far_model (
    // Link
    input wire logic sck_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic sck_o,
    output logic sck_oe_o,
    // Bench side
    output logic [15:0] rx_word_o
);
    logic [15:0] tx_reg = 16'h0000;
    initial begin
        miso_o = 1'b0;
        sck_o = 1'b0;
        sck_oe_o = 1'b0;
        rx_word_o = 16'h0000;
    end
    // Sample on the leading edge, change on the trailing one
    always @(posedge sck_i) rx_word_o <= {rx_word_o[14:0], mosi_i};
    always @(negedge sck_i) begin
        tx_reg <= {tx_reg[14:0], ~tx_reg[0]};
        miso_o <= tx_reg[14];
    end
    task automatic load(input logic [15:0] w);
        tx_reg <= w;
        miso_o <= w[15];
    endtask
    // Clock only within the frame, odd phase against the system clock
    task automatic gen_frame(input int n);
        #3 sck_oe_o = 1'b1;
        repeat (n) begin
            #40 sck_o = 1'b1;
            #40 sck_o = 1'b0;
        end
        #40 sck_oe_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench of the framed serial port against a far-side model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'h3;
    logic idle_mode_i = 1'b0;
    wire logic [31:0] avs_readdata_o;
    wire logic avs_waitrequest_o, shift_clock_pin_o, shift_clock_pin_oe_n_o, serial_out_pin_o;
    wire logic serial_out_pin_oe_n_o, select_pin_o, select_pin_oe_n_o, far_sck, far_sck_oe, far_miso;
    wire logic [15:0] far_rx;
    // Clock line pulled low, data and select lines pulled high when released
    wire logic sck_line = !shift_clock_pin_oe_n_o ? shift_clock_pin_o : far_sck_oe && far_sck;
    wire logic sdo_line = serial_out_pin_oe_n_o | serial_out_pin_o;
    wire logic sel_line = select_pin_oe_n_o | select_pin_o;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;
    spi_framed_port spi_framed_port_inst (.mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .idle_mode_i(idle_mode_i), .shift_clock_pin_i(sck_line),
        .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe_n_o(shift_clock_pin_oe_n_o),
        .serial_in_pin_i(far_miso), .serial_out_pin_o(serial_out_pin_o),
        .serial_out_pin_oe_n_o(serial_out_pin_oe_n_o), .select_pin_i(sel_line), .select_pin_o(select_pin_o),
        .select_pin_oe_n_o(select_pin_oe_n_o));
    spi_far_model spi_far_model_inst (.sck_i(sck_line), .mosi_i(sdo_line), .miso_o(far_miso),
        .sck_o(far_sck), .sck_oe_o(far_sck_oe), .rx_word_o(far_rx));
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic wr, input logic [15:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= {16'h0000, d};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 16'h0000, q);
        check(q, exp);
    endtask
    task automatic wait_flag(input int bitn);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            bus(spi_port_pkg::OFS_STATUS, 1'b0, 16'h0000, q);
            n++;
        end while (q[bitn] !== 1'b1 && n < 300);
    endtask
    task automatic pins_chk(input logic [2:0] exp);
        @(negedge mclk_i);
        check({29'h0, shift_clock_pin_oe_n_o, serial_out_pin_oe_n_o, select_pin_oe_n_o}, {29'h0, exp});
    endtask
    task automatic test_regs;
        rd_chk(spi_port_pkg::OFS_STATUS, 32'h0000_0000);
        rd_chk(spi_port_pkg::OFS_CON1, 32'h0000_0000);
        wr(spi_port_pkg::OFS_CON1, 16'hFFFF);
        rd_chk(spi_port_pkg::OFS_CON1, 32'h0000_1FFF);
        wr(spi_port_pkg::OFS_CON2, 16'hFFFF);
        rd_chk(spi_port_pkg::OFS_CON2, 32'h0000_E002);
        wr(4'h5, 16'hFFFF);
        rd_chk(4'h5, 32'h0000_0000);
        wr(spi_port_pkg::OFS_CON2, 16'h0000);
        wr(spi_port_pkg::OFS_CON1, 16'h0000);
        wr(spi_port_pkg::OFS_STATUS, 16'hFFFF);
        rd_chk(spi_port_pkg::OFS_STATUS, 32'h0000_A000);
        wr(spi_port_pkg::OFS_STATUS, 16'h0000);
        $display("register test done");
    endtask
    task automatic test_master16;
        spi_far_model_inst.load(16'hA5C3);
        idle_mode_i <= 1'b1;
        wr(spi_port_pkg::OFS_CON1, 16'h053A);
        wr(spi_port_pkg::OFS_STATUS, 16'hA000);
        wr(spi_port_pkg::OFS_DATA, 16'h3C5A);
        repeat (40) @(posedge mclk_i);
        rd_chk(spi_port_pkg::OFS_STATUS, 32'h0000_A002);
        idle_mode_i <= 1'b0;
        wait_flag(0);
        rd_chk(spi_port_pkg::OFS_STATUS, 32'h0000_A001);
        rd_chk(spi_port_pkg::OFS_DATA, 32'h0000_A5C3);
        check({16'h0000, far_rx}, 32'h0000_3C5A);
        rd_chk(spi_port_pkg::OFS_STATUS, 32'h0000_A000);
        $display("master word test done");
    endtask
    task automatic test_overflow8;
        wr(spi_port_pkg::OFS_STATUS, 16'h8000);
        wr(spi_port_pkg::OFS_CON1, 16'h033A);
        spi_far_model_inst.load(16'h9600);
        wr(spi_port_pkg::OFS_DATA, 16'h0069);
        wait_flag(0);
        spi_far_model_inst.load(16'h3C00);
        wr(spi_port_pkg::OFS_DATA, 16'h00F0);
        wait_flag(6);
        rd_chk(spi_port_pkg::OFS_STATUS, 32'h0000_8041);
        check({24'h0, far_rx[7:0]}, 32'h0000_00F0);
        rd_chk(spi_port_pkg::OFS_DATA, 32'h0000_0096);
        wr(spi_port_pkg::OFS_STATUS, 16'h8000);
        rd_chk(spi_port_pkg::OFS_STATUS, 32'h0000_8000);
        $display("byte overflow test done");
    endtask
    task automatic test_pins;
        wr(spi_port_pkg::OFS_CON1, 16'h183A);
        pins_chk(3'b111);
        wr(spi_port_pkg::OFS_CON1, 16'h007A);
        pins_chk(3'b001);
        check({31'h0, shift_clock_pin_o}, 32'h0000_0001);
        wr(spi_port_pkg::OFS_STATUS, 16'h0000);
        pins_chk(3'b111);
        $display("pin ownership test done");
    endtask
    task automatic test_framed;
        int hi;
        logic [31:0] q;
        hi = 0;
        wr(spi_port_pkg::OFS_CON1, 16'h043A);
        wr(spi_port_pkg::OFS_CON2, 16'hA000);
        wr(spi_port_pkg::OFS_STATUS, 16'h8000);
        pins_chk(3'b000);
        check({31'h0, select_pin_o}, 32'h0000_0000);
        wr(spi_port_pkg::OFS_DATA, 16'h8001);
        repeat (300) begin
            @(negedge mclk_i);
            if (select_pin_o === 1'b1) hi++;
        end
        // Pulse spans two ticks of eight system clocks ahead of the first bit
        check(hi, 32'h0000_0010);
        wait_flag(0);
        bus(spi_port_pkg::OFS_DATA, 1'b0, 16'h0000, q);
        wr(spi_port_pkg::OFS_CON2, 16'h0000);
        $display("frame sync test done");
    endtask
    task automatic test_slave;
        wr(spi_port_pkg::OFS_STATUS, 16'h0000);
        wr(spi_port_pkg::OFS_CON1, 16'h0500);
        wr(spi_port_pkg::OFS_STATUS, 16'h8000);
        pins_chk(3'b101);
        wr(spi_port_pkg::OFS_DATA, 16'h1234);
        spi_far_model_inst.load(16'hBEEF);
        spi_far_model_inst.gen_frame(16);
        wait_flag(0);
        rd_chk(spi_port_pkg::OFS_DATA, 32'h0000_BEEF);
        check({16'h0000, far_rx}, 32'h0000_1234);
        $display("slave test done");
    endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        srst_i <= 1'b0;
        test_regs();
        test_master16();
        test_overflow8();
        test_pins();
        test_framed();
        test_slave();
        complete_run();
    end
endmodule
`default_nettype wire
